/* File: shared/ccb_pkg.sv */
// Shared constants and carriers for the call/compare/decimal execution block.
// Assumes one clk edge per instruction cycle; Q phases are not modelled.
`default_nettype none
package ccb_pkg;
    localparam int PC_W       = 21;
    localparam int DA_W       = 14;
    localparam int BANK_SEL_W = 6;
    localparam int INSN_W     = 16;

    // Instruction encodings
    localparam logic [15:0] OP_CALL_VIA_ACC  = 16'h0014;
    localparam logic [15:0] OP_DECIMAL_ADJ   = 16'h0007;
    localparam logic [15:0] OP_BYTE_MASK     = 16'hFE00;
    localparam logic [15:0] OP_CMP_SKIP_LESS = 16'h6000;
    localparam logic [15:0] OP_CLEAR_FILE    = 16'h6A00;
    // Two-word instructions: register move, and the 0xEC..0xEF group
    localparam logic [15:0] TWO_WORD_MASK_A  = 16'hF000;
    localparam logic [15:0] TWO_WORD_VAL_A   = 16'hC000;
    localparam logic [15:0] TWO_WORD_MASK_B  = 16'hFC00;
    localparam logic [15:0] TWO_WORD_VAL_B   = 16'hEC00;

    localparam int          ACC_SEL_BIT    = 8;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [5:0]  ACCESS_HI_BANK = 6'h3F;

    localparam logic [20:0] PC_STEP    = 21'h00_0002;
    localparam logic [20:0] PC_RESET   = 21'h00_0000;
    localparam logic [3:0]  BCD_LIMIT  = 4'h9;
    localparam logic [3:0]  BCD_FIX    = 4'h6;
    localparam logic [7:0]  CLEAR_BYTE = 8'h00;
    localparam int          STACK_DEPTH = 31;

    typedef struct packed {
        logic [7:0]            acc;
        logic [BANK_SEL_W-1:0] bank_sel;
        logic [7:0]            latch_high;
        logic [4:0]            latch_upper;
        logic                  carry;
        logic                  half_carry;
        logic                  zero;
    } ccb_arch_t;

    typedef struct packed {
        logic [DA_W-1:0] addr;
        logic [7:0]      wdata;
        logic            we;
    } ccb_dmem_req_t;
endpackage
`default_nettype wire

/* File: logic/ccb_return_stack.sv */
// Hardware return stack with a registered top-of-stack output.
// Assumes the core never pushes and pops in the same cycle; push wins if so.
`default_nettype none
module ccb_return_stack #(
    parameter int DEPTH = 31,
    parameter int WIDTH = 21
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] top,
    output logic                  full
);
    localparam int PW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_ONE  = PW'(1);
    localparam logic [PW-1:0] PTR_TWO  = PW'(2);
    localparam logic [PW-1:0] PTR_FULL = PW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    ptr;

    assign full = (ptr == PTR_FULL);

    // Pushes on a full stack are dropped so that older return addresses live
    always_ff @(posedge clk) begin
        if (push && !full) begin
            mem[ptr] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ptr <= '0;
        end else if (push) begin
            if (!full) begin
                ptr <= ptr + PTR_ONE;
            end
        end else if (pop && ptr != '0) begin
            ptr <= ptr - PTR_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            top <= '0;
        end else if (push) begin
            if (!full) begin
                top <= push_data;
            end
        end else if (pop && ptr != '0) begin
            top <= (ptr >= PTR_TWO) ? mem[ptr - PTR_TWO] : '0;
        end
    end
endmodule // ccb_return_stack
`default_nettype wire

/* File: logic/ccb_exec.sv */
// Fetch and execute for four core instructions: indirect call, clear file
// byte, compare-skip-if-less and decimal adjust.
// Assumes program and data memory answer combinationally in the same cycle.
`default_nettype none
// Behaviour
// [RULE1] Indirect call pushes its own address plus two onto the stack top.
// [RULE2] Indirect call loads program counter low byte from the accumulator.
// [RULE3] Indirect call copies high and upper latches into the counter.
// [RULE4] Indirect call takes two cycles; second is a bubble.
// [RULE5] Indirect call leaves accumulator, flags and bank select untouched.
// [RULE6] Compare subtracts unsigned, stores nothing, changes no flag.
// [RULE7] When byte is less than accumulator, next word becomes a bubble.
// [RULE8] Access bit zero addresses the fixed access bank.
// [RULE9] Access bit one forms the address from bank select.
// [RULE10] Decimal adjust fixes the accumulator to packed BCD in one cycle.
// [RULE11] Low nibble above nine or half carry set adds six.
// [RULE12] High nibble gets plus half carry, plus six when above nine or carry.
// [RULE13] Decimal adjust sets carry on decimal carry out, else keeps it.
// [RULE14] Clear file byte writes zero, sets zero flag, in one cycle.
// [RULE15] Skipping a two-word instruction costs three cycles in total.
module ccb_exec #(
    parameter int STACK_DEPTH = ccb_pkg::STACK_DEPTH
) (
    input  wire logic                         clk,
    input  wire logic                         srst,
    output logic      [ccb_pkg::PC_W-1:0]     prog_addr,
    input  wire logic [ccb_pkg::INSN_W-1:0]   prog_data,
    output ccb_pkg::ccb_dmem_req_t            dmem_req,
    input  wire logic [7:0]                   dmem_rdata,
    input  wire logic                         arch_load_valid,
    input  wire ccb_pkg::ccb_arch_t           arch_load,
    output ccb_pkg::ccb_arch_t                arch,
    input  wire logic                         stack_pop,
    output logic      [ccb_pkg::PC_W-1:0]     stack_top,
    output logic                              stack_full,
    output logic                              exec_valid
);
    typedef enum logic [4:0] {
        CCB_OTHER  = 5'b00001,
        CCB_CALL   = 5'b00010,
        CCB_CMPLT  = 5'b00100,
        CCB_CLEAR  = 5'b01000,
        CCB_DECADJ = 5'b10000
    } ccb_op_t;

    logic [ccb_pkg::PC_W-1:0]   pc;
    logic [ccb_pkg::INSN_W-1:0] ir;
    logic [ccb_pkg::PC_W-1:0]   ir_pc;
    logic                       ir_valid;
    logic                       squash_second;
    ccb_op_t                    op;
    logic                       skip;
    logic                       fetched_two_word;
    logic [ccb_pkg::PC_W-1:0]   call_target;
    logic [7:0]                 file_sel;
    logic [ccb_pkg::DA_W-1:0]   file_addr;
    logic [7:0]                 adj_result;
    logic                       adj_carry;

    assign prog_addr  = pc;
    assign exec_valid = ir_valid;

    always_comb begin
        op = CCB_OTHER;
        if (ir_valid) begin
            if (ir == ccb_pkg::OP_CALL_VIA_ACC) begin
                op = CCB_CALL;
            end else if (ir == ccb_pkg::OP_DECIMAL_ADJ) begin
                op = CCB_DECADJ;
            end else if ((ir & ccb_pkg::OP_BYTE_MASK) ==
                         ccb_pkg::OP_CMP_SKIP_LESS) begin
                op = CCB_CMPLT;
            end else if ((ir & ccb_pkg::OP_BYTE_MASK) ==
                         ccb_pkg::OP_CLEAR_FILE) begin
                op = CCB_CLEAR;
            end
        end
    end

    // File address: access bank split or bank-select page
    assign file_sel = ir[7:0];
    always_comb begin
        if (ir[ccb_pkg::ACC_SEL_BIT]) begin
            file_addr = {arch.bank_sel, file_sel}; // RULE9
        end else if (file_sel < ccb_pkg::ACCESS_SPLIT) begin
            file_addr = {{ccb_pkg::BANK_SEL_W{1'b0}}, file_sel}; // RULE8
        end else begin
            file_addr = {ccb_pkg::ACCESS_HI_BANK, file_sel}; // RULE8
        end
    end

    assign dmem_req.addr  = file_addr;
    assign dmem_req.wdata = ccb_pkg::CLEAR_BYTE; // RULE14
    assign dmem_req.we    = (op == CCB_CLEAR); // RULE14

    // Unsigned compare; the difference is never stored
    assign skip = (op == CCB_CMPLT) && (dmem_rdata < arch.acc); // RULE6

    assign fetched_two_word =
        ((prog_data & ccb_pkg::TWO_WORD_MASK_A) == ccb_pkg::TWO_WORD_VAL_A) ||
        ((prog_data & ccb_pkg::TWO_WORD_MASK_B) == ccb_pkg::TWO_WORD_VAL_B);

    assign call_target = {arch.latch_upper, arch.latch_high, arch.acc};

    // Decimal adjust, nibble by nibble
    always_comb begin
        logic [3:0] lo;
        logic [4:0] hi_sum;
        logic [4:0] hi;
        lo     = arch.acc[3:0];
        hi_sum = {1'b0, arch.acc[7:4]} + {4'h0, arch.half_carry};
        hi     = hi_sum;
        if (lo > ccb_pkg::BCD_LIMIT || arch.half_carry) begin
            lo = lo + ccb_pkg::BCD_FIX; // RULE11
        end
        if (hi_sum > {1'b0, ccb_pkg::BCD_LIMIT} || arch.carry) begin
            hi = hi_sum + {1'b0, ccb_pkg::BCD_FIX}; // RULE12
        end else begin
            hi = hi_sum; // RULE12
        end
        adj_result = {hi[3:0], lo}; // RULE10
        adj_carry  = arch.carry | hi[4]; // RULE13
    end

    // Fetch: each word in prog_data is latched as the next instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            pc <= ccb_pkg::PC_RESET;
        end else if (op == CCB_CALL) begin
            pc <= call_target; // RULE2 RULE3
        end else begin
            pc <= pc + ccb_pkg::PC_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ir    <= '0;
            ir_pc <= ccb_pkg::PC_RESET;
        end else begin
            ir    <= prog_data;
            ir_pc <= pc;
        end
    end

    // Redirect and skip both turn the word in flight into a bubble
    always_ff @(posedge clk) begin
        if (srst) begin
            ir_valid <= 1'b0;
        end else if (op == CCB_CALL) begin
            ir_valid <= 1'b0; // RULE4
        end else if (skip) begin
            ir_valid <= 1'b0; // RULE7
        end else if (squash_second) begin
            ir_valid <= 1'b0; // RULE15
        end else begin
            ir_valid <= 1'b1;
        end
    end

    // Second word of a skipped two-word instruction is discarded too
    always_ff @(posedge clk) begin
        if (srst) begin
            squash_second <= 1'b0;
        end else begin
            squash_second <= skip && fetched_two_word; // RULE15
        end
    end

    // Architectural state; an external load outranks the instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            arch <= '0;
        end else if (arch_load_valid) begin
            arch <= arch_load;
        end else begin
            case (op)
                CCB_DECADJ: begin
                    arch.acc   <= adj_result; // RULE10
                    arch.carry <= adj_carry; // RULE13
                end
                CCB_CLEAR: begin
                    arch.zero <= 1'b1; // RULE14
                end
                CCB_CALL, CCB_CMPLT, CCB_OTHER: begin
                    arch <= arch; // RULE5 RULE6
                end
                default: begin
                    arch <= arch;
                end
            endcase
        end
    end

    ccb_return_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (ccb_pkg::PC_W)
    ) u_stack (
        .clk       (clk),
        .srst      (srst),
        .push      (op == CCB_CALL), // RULE1
        .push_data (ir_pc + ccb_pkg::PC_STEP), // RULE1
        .pop       (stack_pop),
        .top       (stack_top),
        .full      (stack_full)
    );

    sequence s_bubble;
        !ir_valid;
    endsequence

    sequence s_two_bubbles;
        !ir_valid ##1 !ir_valid;
    endsequence

    property p_call_push;
        @(posedge clk) disable iff (srst)
        (op == CCB_CALL) && !stack_full && !$past(srst)
        |=> stack_top == $past(ir_pc) + ccb_pkg::PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) // RULE1
        else $error("return address not pushed");

    property p_call_target;
        @(posedge clk) disable iff (srst)
        (op == CCB_CALL) |=> prog_addr[7:0] == $past(arch.acc);
    endproperty
    a_call_target: assert property (p_call_target) // RULE2
        else $error("call target wrong");

    property p_call_upper;
        @(posedge clk) disable iff (srst)
        (op == CCB_CALL)
        |=> prog_addr[20:8] == $past({arch.latch_upper, arch.latch_high});
    endproperty
    a_call_upper: assert property (p_call_upper) // RULE3
        else $error("upper counter bytes not from latches");

    property p_call_bubble;
        @(posedge clk) disable iff (srst)
        (op == CCB_CALL) |=> s_bubble ##1 ir_valid;
    endproperty
    a_call_bubble: assert property (p_call_bubble) // RULE4
        else $error("call did not take two cycles");

    property p_call_keep;
        @(posedge clk) disable iff (srst)
        (op == CCB_CALL) && !arch_load_valid |=> $stable(arch);
    endproperty
    a_call_keep: assert property (p_call_keep) // RULE5
        else $error("call changed state");

    property p_cmp_keep;
        @(posedge clk) disable iff (srst)
        (op == CCB_CMPLT) && !arch_load_valid
        |-> !dmem_req.we ##1 $stable(arch);
    endproperty
    a_cmp_keep: assert property (p_cmp_keep) // RULE6
        else $error("compare altered state");

    property p_skip;
        @(posedge clk) disable iff (srst)
        (op == CCB_CMPLT) && (dmem_rdata < arch.acc) |=> s_bubble;
    endproperty
    a_skip: assert property (p_skip) // RULE7
        else $error("skip did not discard next word");

    property p_no_skip;
        @(posedge clk) disable iff (srst)
        (op == CCB_CMPLT) && !(dmem_rdata < arch.acc) && !squash_second
        |=> ir_valid;
    endproperty
    a_no_skip: assert property (p_no_skip) // RULE7
        else $error("compare skipped while not less");

    property p_access;
        @(posedge clk) disable iff (srst)
        (op == CCB_CMPLT) && !ir[ccb_pkg::ACC_SEL_BIT]
        && ir[7:0] < ccb_pkg::ACCESS_SPLIT
        |-> dmem_req.addr == {{ccb_pkg::BANK_SEL_W{1'b0}}, ir[7:0]};
    endproperty
    a_access: assert property (p_access) // RULE8
        else $error("access bank address wrong");

    property p_banked;
        @(posedge clk) disable iff (srst)
        (op == CCB_CMPLT || op == CCB_CLEAR) && ir[ccb_pkg::ACC_SEL_BIT]
        |-> dmem_req.addr == {arch.bank_sel, ir[7:0]};
    endproperty
    a_banked: assert property (p_banked) // RULE9
        else $error("banked address wrong");

    property p_adj_carry_keep;
        @(posedge clk) disable iff (srst)
        (op == CCB_DECADJ) && arch.carry && !arch_load_valid |=> arch.carry;
    endproperty
    a_adj_carry_keep: assert property (p_adj_carry_keep) // RULE13
        else $error("decimal adjust dropped carry");

    property p_adj_low;
        @(posedge clk) disable iff (srst)
        (op == CCB_DECADJ) && !arch_load_valid && !arch.half_carry
        && arch.acc[3:0] <= ccb_pkg::BCD_LIMIT
        |=> arch.acc[3:0] == $past(arch.acc[3:0]);
    endproperty
    a_adj_low: assert property (p_adj_low) // RULE11
        else $error("valid low digit was changed");

    property p_clear;
        @(posedge clk) disable iff (srst)
        (op == CCB_CLEAR) && !arch_load_valid
        |-> dmem_req.we && dmem_req.wdata == ccb_pkg::CLEAR_BYTE
            ##1 arch.zero;
    endproperty
    a_clear: assert property (p_clear) // RULE14
        else $error("clear did not write zero and set zero flag");

    property p_skip_two;
        @(posedge clk) disable iff (srst)
        skip && fetched_two_word |=> s_two_bubbles;
    endproperty
    a_skip_two: assert property (p_skip_two) // RULE15
        else $error("two-word skip not three cycles");
endmodule // ccb_exec
`default_nettype wire

/* File: bench/ccb_mem_model.sv */
// Program and data memory standing beside the execution block.
// Assumes single-cycle combinational reads, as the block expects.
`default_nettype none
module ccb_mem_model (
    input  wire logic                       clk,
    input  wire logic [ccb_pkg::PC_W-1:0]   prog_addr,
    output logic      [ccb_pkg::INSN_W-1:0] prog_data,
    input  wire ccb_pkg::ccb_dmem_req_t     dmem_req,
    output logic      [7:0]                 dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Small program store; wider addresses alias, which is harmless here
    logic [15:0] prog [256];
    logic [7:0]  dmem [16384];

    initial begin
        for (int i = 0; i < 16384; i++) begin
            dmem[i] = 8'h00;
        end
    end

    assign prog_data  = prog[prog_addr[8:1]];
    assign dmem_rdata = dmem[dmem_req.addr];

    // Plain always: the bench also preloads bytes between runs
    always @(posedge clk) begin
        if (dmem_req.we) begin
            dmem[dmem_req.addr] <= dmem_req.wdata;
        end
    end
endmodule // ccb_mem_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the call/clear/compare/decimal execution block.
// Assumes the memory model answers reads in the same cycle.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         clk;
    logic                         srst;
    logic [ccb_pkg::PC_W-1:0]     prog_addr;
    logic [ccb_pkg::INSN_W-1:0]   prog_data;
    ccb_pkg::ccb_dmem_req_t       dmem_req;
    logic [7:0]                   dmem_rdata;
    logic                         arch_load_valid;
    ccb_pkg::ccb_arch_t           arch_load;
    ccb_pkg::ccb_arch_t           arch;
    logic                         stack_pop;
    logic [ccb_pkg::PC_W-1:0]     stack_top;
    logic                         stack_full;
    logic                         exec_valid;
    int                           num_errors;
    int                           compares;
    logic [31:0]                  seed;

    ccb_exec ccb_exec_i (
        .clk(clk), .srst(srst), .prog_addr(prog_addr),
        .prog_data(prog_data), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata), .arch_load_valid(arch_load_valid),
        .arch_load(arch_load), .arch(arch), .stack_pop(stack_pop),
        .stack_top(stack_top), .stack_full(stack_full),
        .exec_valid(exec_valid)
    );

    ccb_mem_model ccb_mem_model_i (
        .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic ccb_pkg::ccb_arch_t rand_arch();
        logic [31:0] r;
        r = rnd();
        return r[29:0];
    endfunction

    function automatic logic [13:0] ea(logic ab, logic [7:0] f,
                                       logic [5:0] b);
        if (ab) return {b, f};
        if (f < ccb_pkg::ACCESS_SPLIT) return {6'h00, f};
        return {ccb_pkg::ACCESS_HI_BANK, f};
    endfunction

    // Nibbles corrected independently; returns {carry, result}
    function automatic logic [8:0] dec_adj(logic [7:0] w, logic c, logic hc);
        logic [3:0] lo;
        logic [4:0] hi;
        lo = (w[3:0] > 4'h9 || hc) ? w[3:0] + 4'h6 : w[3:0];
        hi = {1'b0, w[7:4]} + {4'h0, hc};
        hi = (hi > 5'h09 || c) ? hi + 5'h06 : hi;
        return {c | hi[4], hi[3:0], lo};
    endfunction

    task automatic end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #3;
    endtask

    // Leaves the bench in cycle 1, with word 0 executing
    task automatic setup(input ccb_pkg::ccb_arch_t a, input logic [15:0] w0,
                         input logic [15:0] w1, input logic [13:0] da,
                         input logic [7:0] dv);
        for (int i = 0; i < 256; i++) begin
            ccb_mem_model_i.prog[i] = 16'h0000;
        end
        ccb_mem_model_i.prog[0] = w0;
        ccb_mem_model_i.prog[1] = w1;
        ccb_mem_model_i.dmem[da] = dv;
        srst = 1'b1;
        step();
        step();
        srst = 1'b0;
        arch_load = a;
        arch_load_valid = 1'b1;
        step();
        arch_load_valid = 1'b0;
    endtask

    task automatic run_call();
        ccb_pkg::ccb_arch_t a;
        logic [20:0]        tgt;
        a = rand_arch();
        // Keeps the target clear of the words at the start of memory
        a.acc = a.acc | 8'h08;
        tgt = {a.latch_upper, a.latch_high, a.acc};
        setup(a, 16'h0000, 16'h0014, 14'h0000, 8'h00);
        step();
        chk(32'(exec_valid), 32'h0000_0001);
        step();
        chk(32'(prog_addr), 32'(tgt));
        chk(32'(stack_top), 32'h0000_0004);
        chk(32'(stack_full), 32'h0000_0000);
        chk(32'(exec_valid), 32'h0000_0000);
        chk(32'(arch), 32'(a));
        step();
        chk(32'(exec_valid), 32'h0000_0001);
        stack_pop = 1'b1;
        step();
        stack_pop = 1'b0;
        chk(32'(stack_top), 32'h0000_0000);
    endtask

    task automatic run_adj(input int n);
        ccb_pkg::ccb_arch_t a;
        ccb_pkg::ccb_arch_t e;
        logic [8:0]         d;
        a = rand_arch();
        if (n == 0) a.acc = 8'hA5;
        if (n == 1) a.acc = 8'hCE;
        if (n == 2) a.acc = 8'h9F;
        if (n < 3) a.carry = 1'b0;
        if (n < 3) a.half_carry = (n == 2);
        d = dec_adj(a.acc, a.carry, a.half_carry);
        e = a;
        e.acc = d[7:0];
        e.carry = d[8];
        setup(a, 16'h0007, 16'h0000, 14'h0000, 8'h00);
        step();
        chk(32'(arch), 32'(e));
    endtask

    task automatic run_clr(input int n);
        ccb_pkg::ccb_arch_t a;
        ccb_pkg::ccb_arch_t e;
        logic [31:0]        r;
        logic [7:0]         f;
        logic               ab;
        logic [13:0]        da;
        a = rand_arch();
        a.zero = 1'b0;
        r = rnd();
        f = (n == 0) ? 8'h5F : (n == 1) ? 8'h60 : r[7:0];
        ab = (n < 2) ? 1'b0 : r[8];
        da = ea(ab, f, a.bank_sel);
        e = a;
        e.zero = 1'b1;
        setup(a, {7'h35, ab, f}, 16'h0000, da, 8'h5A);
        chk(32'(dmem_req.we), 32'h0000_0001);
        chk(32'(dmem_req.addr), 32'(da));
        chk(32'(dmem_req.wdata), 32'h0000_0000);
        step();
        chk(32'(arch), 32'(e));
        chk(32'(ccb_mem_model_i.dmem[da]), 32'h0000_0000);
    endtask

    task automatic run_cmp(input int n);
        ccb_pkg::ccb_arch_t a;
        logic [31:0]        r;
        logic [7:0]         v;
        logic [15:0]        w1;
        logic [13:0]        da;
        logic               skip;
        logic               tw;
        a = rand_arch();
        r = rnd();
        v = r[23:16];
        if (n == 0) v = a.acc;
        if (n == 1) v = a.acc - 8'h01;
        case (r[25:24])
            2'b00: w1 = 16'hC123;
            2'b01: w1 = 16'hEF45;
            default: w1 = 16'h0000;
        endcase
        tw = (w1 != 16'h0000);
        skip = (v < a.acc);
        da = ea(r[8], r[7:0], a.bank_sel);
        setup(a, {7'h30, r[8:0]}, w1, da, v);
        chk(32'(dmem_req.addr), 32'(da));
        chk(32'(dmem_req.we), 32'h0000_0000);
        step();
        chk(32'(exec_valid), 32'(!skip));
        chk(32'(arch), 32'(a));
        step();
        if (skip) chk(32'(exec_valid), 32'(!tw));
        step();
        if (skip) chk(32'(exec_valid), 32'h0000_0001);
    endtask

    initial begin
        srst = 1'b1;
        arch_load_valid = 1'b0;
        arch_load = '0;
        stack_pop = 1'b0;
        num_errors = 0;
        compares = 0;
        seed = 32'h7539;
        for (int n = 0; n < 24; n++) begin
            run_call();
            run_adj(n);
            run_clr(n);
            run_cmp(n);
        end
        end_sim();
    end

    // A hang counts as a mismatch
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule // tb
`default_nettype wire
